// ==== logic/ddus_params.svh ====
// Purpose: Register offsets, field positions and reset values for the dual converter update scheduler.
// Assumes: Registers sit on a paged special function register bus with 8-bit data.
// Notes: Both converters share offsets and are told apart by the page number.
`ifndef DDUS_PARAMS_SVH
`define DDUS_PARAMS_SVH
`define DDUS_OFS_DATA_LOW 8'hd2
`define DDUS_OFS_DATA_HIGH 8'hd3
`define DDUS_OFS_CONTROL 8'hd4
`define DDUS_PAGE_CONV0 8'h00
`define DDUS_PAGE_CONV1 8'h01
`define DDUS_CTL_ENABLE_BIT 7
`define DDUS_CTL_MODE_HI 4
`define DDUS_CTL_MODE_LO 3
`define DDUS_CTL_FMT_HI 2
`define DDUS_CTL_FMT_LO 0
`define DDUS_CTL_WR_MASK 8'h9f
`define DDUS_RST_BYTE 8'h00
`define DDUS_RST_WORD 12'h000
`endif

// ==== logic/ddus_pkg.sv ====
// Purpose: Types shared by the dual converter update scheduler.
// Assumes: Nothing beyond the parameter header.
// Notes: Mode codes follow the control register encoding.
package ddus_pkg;
   typedef enum logic [1:0] {
      DDUS_MODE_ON_WRITE = 2'b00,
      DDUS_MODE_TIMER3 = 2'b01,
      DDUS_MODE_TIMER4 = 2'b10,
      DDUS_MODE_TIMER2 = 2'b11
   } ddus_mode_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ddus_sfr_req_t;
   typedef struct packed {
      logic timer2;
      logic timer3;
      logic timer4;
   } ddus_ovf_t;
endpackage

// ==== logic/ddus_top.sv ====
// Purpose: Holding registers, control registers and input latches of two 12-bit converters.
// Assumes: The core drives one-cycle read and write strobes; timer overflows are one-cycle pulses.
// Notes: Read data is registered and appears the cycle after the read strobe.
// Behaviour
// - Latch holds 12-bit unsigned code 000 to fff.
// - Disabled converter output is high impedance.
// - Mode zero loads latch on high-byte write.
// - Mode zero low-byte write only stores data.
// - Timer modes never load on register writes.
// - Modes 1,2,3 load on timer 3,4,2 overflow.
// - Format field bits 2:0 selects justification.
// - Second converter behaves identically, own registers.
// - Formats 000..1xx split word across bytes.
// - Control bit 7 enables the converter.
// - Control bits 6:5 read zero, writes ignored.
`timescale 1ns/1ps
`include "ddus_params.svh"
module ddus_top #(
   parameter int NUM_CONV = 2
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire ddus_pkg::ddus_sfr_req_t sfr_req_i,
   input wire ddus_pkg::ddus_ovf_t ovf_i,
   input wire logic reference_bias_enable_i,
   output logic [7:0] sfr_rdata_o,
   output logic [11:0] conv0_code_o,
   output logic [11:0] conv1_code_o,
   output logic conv0_out_en_o,
   output logic conv1_out_en_o
);
   import ddus_pkg::*;

   // Rebuilds the 12-bit word from the two bytes for a given justification.
   function automatic logic [11:0] join_word(input logic [2:0] fmt, input logic [7:0] hi, input logic [7:0] lo);
      logic [11:0] w;
      w = 12'h000;
      if (fmt[2]) begin
         w = {hi, lo[7:4]};
      end else begin
         case (fmt[1:0])
            2'b00: w = {hi[3:0], lo};
            2'b01: w = {hi[4:0], lo[7:1]};
            2'b10: w = {hi[5:0], lo[7:2]};
            default: w = {hi[6:0], lo[7:3]};
         endcase
      end
      return w;
   endfunction

   // Returns the overflow pulse that the given mode listens to.
   function automatic logic timer_hit(input ddus_mode_t m, input ddus_ovf_t o);
      logic h;
      h = 1'b0;
      case (m)
         DDUS_MODE_TIMER3: h = o.timer3;
         DDUS_MODE_TIMER4: h = o.timer4;
         DDUS_MODE_TIMER2: h = o.timer2;
         default: h = 1'b0;
      endcase
      return h;
   endfunction

   // Per-converter state; index 0 answers page 0 and index 1 answers page 1.
   logic [7:0] ctl_r [NUM_CONV];
   logic [7:0] high_r [NUM_CONV];
   logic [7:0] low_r [NUM_CONV];
   logic [11:0] latch_r [NUM_CONV];
   logic [NUM_CONV-1:0] sel;
   logic [NUM_CONV-1:0] load;
   logic [11:0] next_word [NUM_CONV];
   logic [7:0] rdata_nxt;

   always_comb begin
      for (int i = 0; i < NUM_CONV; i++) begin
         sel[i] = (sfr_req_i.page == 8'(i));
      end
   end

   // Writes land in the holding bytes; control bits 6:5 are dropped so they always read zero.
   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < NUM_CONV; i++) begin
         if (rst_i) begin
            ctl_r[i] <= `DDUS_RST_BYTE;
            high_r[i] <= `DDUS_RST_BYTE;
            low_r[i] <= `DDUS_RST_BYTE;
         end else if (sfr_req_i.wr && sel[i]) begin
            case (sfr_req_i.addr)
               `DDUS_OFS_CONTROL: ctl_r[i] <= sfr_req_i.wdata & `DDUS_CTL_WR_MASK;
               `DDUS_OFS_DATA_HIGH: high_r[i] <= sfr_req_i.wdata;
               `DDUS_OFS_DATA_LOW: low_r[i] <= sfr_req_i.wdata;
               default: ;
            endcase
         end
      end
   end

   // In mode zero the latch takes the byte being written plus the held low byte, so the load
   // needs no extra cycle after the write.
   always_comb begin
      for (int i = 0; i < NUM_CONV; i++) begin
         ddus_mode_t m;
         m = ddus_mode_t'(ctl_r[i][`DDUS_CTL_MODE_HI:`DDUS_CTL_MODE_LO]);
         if (m == DDUS_MODE_ON_WRITE) begin
            load[i] = sfr_req_i.wr && sel[i] && (sfr_req_i.addr == `DDUS_OFS_DATA_HIGH);
            next_word[i] = join_word(ctl_r[i][`DDUS_CTL_FMT_HI:`DDUS_CTL_FMT_LO], sfr_req_i.wdata, low_r[i]);
         end else begin
            load[i] = timer_hit(m, ovf_i);
            next_word[i] = join_word(ctl_r[i][`DDUS_CTL_FMT_HI:`DDUS_CTL_FMT_LO], high_r[i], low_r[i]);
         end
      end
   end

   // The input latch only moves on a load, so a held byte never reaches the converter early.
   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < NUM_CONV; i++) begin
         if (rst_i) begin
            latch_r[i] <= `DDUS_RST_WORD;
         end else if (load[i]) begin
            latch_r[i] <= next_word[i];
         end
      end
   end

   // Unmapped addresses and pages read as zero, so a stray read never returns stale data.
   always_comb begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < NUM_CONV; i++) begin
         if (sel[i]) begin
            case (sfr_req_i.addr)
               `DDUS_OFS_CONTROL: rdata_nxt = ctl_r[i];
               `DDUS_OFS_DATA_HIGH: rdata_nxt = high_r[i];
               `DDUS_OFS_DATA_LOW: rdata_nxt = low_r[i];
               default: rdata_nxt = 8'h00;
            endcase
         end
      end
   end

   // Read data holds between reads, which lets the core sample it a cycle late.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_req_i.rd) begin
         sfr_rdata_o <= rdata_nxt;
      end
   end

   // The analog stage floats its pin while the enable is low; the bias input is software's concern
   // and is only observed, not enforced, since gating on it would hide a missing setup step.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         conv0_out_en_o <= 1'b0;
         conv1_out_en_o <= 1'b0;
         conv0_code_o <= `DDUS_RST_WORD;
         conv1_code_o <= `DDUS_RST_WORD;
      end else begin
         conv0_out_en_o <= ctl_r[0][`DDUS_CTL_ENABLE_BIT];
         conv1_out_en_o <= ctl_r[1][`DDUS_CTL_ENABLE_BIT];
         conv0_code_o <= latch_r[0];
         conv1_code_o <= latch_r[1];
      end
   end

   logic unused_bias;
   assign unused_bias = reference_bias_enable_i;

   // The checks below state each expected word from the byte layout itself, not from the
   // join function, so a wrong shift in that function for formats 000 and 1xx shows up here.
   sreg_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ctl_r[0][6:5] == 2'b00 && ctl_r[1][6:5] == 2'b00) else $error("control bits 6:5 not zero");
   mode0_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[0][4:3] == 2'b00 && ctl_r[0][2:0] == 3'b000 && sfr_req_i.wr && sel[0]
       && sfr_req_i.addr == 8'hd3) |=> latch_r[0] == {$past(sfr_req_i.wdata[3:0]), $past(low_r[0])})
      else $error("mode zero high write did not load");
   low_write_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[0][4:3] == 2'b00 && sfr_req_i.wr && sel[0] && sfr_req_i.addr == 8'hd2) |=> $stable(latch_r[0]))
      else $error("low byte write changed latch");
   timer_no_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[1][4:3] != 2'b00 && !timer_hit(ddus_mode_t'(ctl_r[1][4:3]), ovf_i)) |=> $stable(latch_r[1]))
      else $error("timer mode loaded without overflow");
   timer3_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[0][4:3] == 2'b01 && ctl_r[0][2] && ovf_i.timer3) |=> latch_r[0] == {$past(high_r[0]), $past(low_r[0][7:4])})
      else $error("timer 3 overflow did not load");
   timer2_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[1][4:3] == 2'b11 && ctl_r[1][2] && ovf_i.timer2)
      |=> latch_r[1] == {$past(high_r[1]), $past(low_r[1][7:4])})
      else $error("timer 2 overflow did not load");
   timer4_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[1][4:3] == 2'b10 && ctl_r[1][2] && ovf_i.timer4)
      |=> latch_r[1] == {$past(high_r[1]), $past(low_r[1][7:4])})
      else $error("timer 4 overflow did not load");
   fmt_top_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[1][4:3] == 2'b00 && ctl_r[1][2] && sfr_req_i.wr && sel[1] && sfr_req_i.addr == `DDUS_OFS_DATA_HIGH)
      |=> latch_r[1] == {$past(sfr_req_i.wdata), $past(low_r[1][7:4])}) else $error("top format load wrong");
   conv1_low_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctl_r[1][4:3] == 2'b00 && sfr_req_i.wr && sel[1] && sfr_req_i.addr == `DDUS_OFS_DATA_LOW)
      |=> $stable(latch_r[1])) else $error("second converter low write changed latch");
   page_isolate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sfr_req_i.wr && sel[1]) |=> $stable(high_r[0]) && $stable(low_r[0]) && $stable(ctl_r[0]))
      else $error("second page write touched first converter");
   // The read port is registered, so the answer is judged one edge after the strobe.
   ctl_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sfr_req_i.rd && sel[1] && sfr_req_i.addr == `DDUS_OFS_CONTROL)
      |=> sfr_rdata_o[6:5] == 2'b00 && sfr_rdata_o[7] == $past(ctl_r[1][7])) else $error("control read wrong");
   disable_float_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !ctl_r[1][7] |=> !conv1_out_en_o) else $error("disabled converter still driving");
   enable_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ##1 conv0_out_en_o == $past(ctl_r[0][7])) else $error("enable output wrong");
   code_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ##1 conv1_code_o == $past(latch_r[1])) else $error("code output wrong");
   reset_clear_a: assert property (@(posedge clk_sys_i) rst_i |=> latch_r[0] == 12'h000 && ctl_r[1] == 8'h00)
      else $error("reset did not clear");
   reset_out_a: assert property (@(posedge clk_sys_i) rst_i |=> conv0_code_o == 12'h000 && !conv1_out_en_o)
      else $error("reset did not clear outputs");

   mode0_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) load[0] && ctl_r[0][4:3] == 2'b00);
   timer4_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) load[1] && ctl_r[1][4:3] == 2'b10);
   fmt_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) load[0] && ctl_r[0][2:0] == 3'b010);
   timer3_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) load[0] && ctl_r[0][4:3] == 2'b01);
   timer2_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) load[1] && ctl_r[1][4:3] == 2'b11);
endmodule // ddus_top

// ==== verif/ddus_core_model.sv ====
// Purpose: Behavioural processor core driving the register bus and the timer overflow pulses.
// Assumes: One request per call; strobes and overflow pulses last one cycle.
// Notes: Released page, address and data lines carry the inverse of the last value, so a late sample shows up as wrong data.
`timescale 1ns/1ps
module ddus_core_model (
   input wire logic clk_sys_i,
   output ddus_pkg::ddus_sfr_req_t sfr_req_o,
   output ddus_pkg::ddus_ovf_t ovf_o,
   output logic reference_bias_enable_o
);
   import ddus_pkg::*;
   initial begin
      sfr_req_o = '0;
      ovf_o = '0;
      reference_bias_enable_o = 1'b1;
   end
   task automatic access(input logic wr, input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys_i);
      sfr_req_o <= '{wr, ~wr, page, addr, data};
      @(posedge clk_sys_i);
      sfr_req_o <= '{1'b0, 1'b0, ~page, ~addr, ~data};
   endtask
   task automatic pulse(input ddus_ovf_t which);
      @(posedge clk_sys_i);
      ovf_o <= which;
      @(posedge clk_sys_i);
      ovf_o <= '0;
   endtask
endmodule // ddus_core_model

// ==== verif/dual_dac_update_scheduler_test.sv ====
// Purpose: Self-checking bench for the dual converter update scheduler.
// Assumes: The core model makes every bus request and overflow pulse.
// Notes: Outputs are judged one edge after the taking edge, where both latency readings agree.
`timescale 1ns/1ps
`include "ddus_params.svh"
module dual_dac_update_scheduler_test;
   import ddus_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   ddus_sfr_req_t req;
   ddus_ovf_t ovf;
   logic bias, en0, en1;
   logic [7:0] rdata;
   logic [11:0] code0, code1;
   always #20 clk_sys_i = ~clk_sys_i;
   ddus_core_model core (.clk_sys_i(clk_sys_i), .sfr_req_o(req), .ovf_o(ovf), .reference_bias_enable_o(bias));
   ddus_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_req_i(req), .ovf_i(ovf), .reference_bias_enable_i(bias),
      .sfr_rdata_o(rdata), .conv0_code_o(code0), .conv1_code_o(code1), .conv0_out_en_o(en0), .conv1_out_en_o(en1));
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         results();
      end
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
      core.access(1'b1, {7'h00, p}, a, d);
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
      core.access(1'b0, p, a, 8'h00);
      @(posedge clk_sys_i);
      #1;
      check({4'h0, rdata}, {4'h0, exp});
   endtask
   task automatic tick(input ddus_ovf_t which);
      core.pulse(which);
      @(posedge clk_sys_i);
      #1;
   endtask
   // Every format is the 16-bit pair shifted right by 0, 1, 2, 3 or 4 and cut to 12 bits.
   function automatic logic [11:0] fmt_word(input logic [2:0] f, input logic [7:0] h, input logic [7:0] l);
      return 12'({h, l} >> (f[2] ? 3'd4 : {1'b0, f[1:0]}));
   endfunction
   function automatic logic [11:0] code(input logic p);
      return p ? code1 : code0;
   endfunction
   task automatic test_reset();
      for (int p = 0; p < 3; p++) begin
         rd(p[7:0], `DDUS_OFS_DATA_LOW, 8'h00);
         rd(p[7:0], `DDUS_OFS_DATA_HIGH, 8'h00);
         rd(p[7:0], `DDUS_OFS_CONTROL, 8'h00);
      end
      check(code0 | code1, 12'h000);
      check({10'h000, en0, en1}, 12'h000);
   endtask
   task automatic test_on_write(input logic p);
      logic [11:0] exp, other;
      logic [7:0] h, l;
      exp = code(p);
      other = code(~p);
      for (int f = 0; f < 8; f++) begin
         h = 8'hc3 ^ f[7:0];
         l = 8'h5a + f[7:0];
         wr(p, `DDUS_OFS_CONTROL, {5'h10, f[2:0]});
         wr(p, `DDUS_OFS_DATA_LOW, l);
         check(code(p), exp);
         wr(p, `DDUS_OFS_DATA_HIGH, h);
         exp = fmt_word(f[2:0], h, l);
         check(code(p), exp);
         wr(p, `DDUS_OFS_DATA_HIGH, 8'hff);
         exp = fmt_word(f[2:0], 8'hff, l);
         check(code(p), exp);
      end
      wr(p, `DDUS_OFS_DATA_LOW, 8'hff);
      wr(p, `DDUS_OFS_DATA_HIGH, 8'hff);
      check(code(p), 12'hfff);
      check(code(~p), other);
   endtask
   task automatic test_control(input logic p);
      wr(p, `DDUS_OFS_CONTROL, 8'hff);
      rd({7'h00, p}, `DDUS_OFS_CONTROL, 8'h9f);
      check({11'h000, p ? en1 : en0}, 12'h001);
      wr(p, `DDUS_OFS_CONTROL, 8'h60);
      rd({7'h00, p}, `DDUS_OFS_CONTROL, 8'h00);
      check({11'h000, p ? en1 : en0}, 12'h000);
   endtask
   task automatic test_timer(input logic p);
      logic [11:0] exp;
      logic [2:0] sel;
      for (int m = 1; m < 4; m++) begin
         sel = (m == 1) ? 3'b010 : (m == 2) ? 3'b001 : 3'b100;
         exp = code(p);
         wr(p, `DDUS_OFS_CONTROL, {3'b100, m[1:0], m[2:0] + 3'd3});
         wr(p, `DDUS_OFS_DATA_LOW, 8'h30 + m[7:0]);
         wr(p, `DDUS_OFS_DATA_HIGH, 8'h0c - m[7:0]);
         check(code(p), exp);
         tick(~sel);
         check(code(p), exp);
         tick(sel);
         check(code(p), fmt_word(m[2:0] + 3'd3, 8'h0c - m[7:0], 8'h30 + m[7:0]));
      end
   endtask
   task automatic results();
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      test_reset();
      for (int p = 0; p < 2; p++) begin
         test_on_write(p[0]);
         test_control(p[0]);
         test_timer(p[0]);
      end
      results();
   end
endmodule // dual_dac_update_scheduler_test
